// ### core/fsr_pkg.sv
// Package of constants for the flash status flag block
package fsr_pkg;

  // ****************************************
  // Command and layout
  // ****************************************
  localparam logic [7:0] OPC_STATUS_READ = 8'hd7;
  localparam int BYTE_BITS = 8;
  localparam logic [2:0] BIT_CNT_LAST = 3'h7;
  localparam logic [2:0] BIT_CNT_RST = 3'h0;

  // First byte field positions
  localparam int B1_IDLE = 7;
  localparam int B1_DIFFER = 6;
  localparam int B1_DENS_HI = 5;
  localparam int B1_DENS_LO = 2;
  localparam int B1_GUARD = 1;
  localparam int B1_BLOCK_LEN = 0;

  // Second byte field positions
  localparam int B2_IDLE = 7;
  localparam int B2_UNUSED_HI = 6;
  localparam int B2_FAULT = 5;
  localparam int B2_UNUSED_LO = 4;
  localparam int B2_LOCKDOWN = 3;
  localparam int B2_SECOND_SUSP = 2;
  localparam int B2_FIRST_SUSP = 1;
  localparam int B2_ERASE_HOLD = 0;

  // ****************************************
  // Values after reset
  // ****************************************
  localparam logic RST_FAULT = 1'b0;
  localparam logic RST_DIFFER = 1'b0;
  localparam logic RST_SUSP = 1'b0;
  localparam logic RST_SO = 1'b0;
  localparam logic RST_PIN_HI = 1'b1;
  localparam logic RST_PIN_LO = 1'b0;
  localparam logic [2:0] RST_SYNC_HI = 3'h7;
  localparam logic [2:0] RST_SYNC_LO = 3'h0;
  localparam logic [7:0] RST_BYTE = 8'h00;

  // ****************************************
  // Link state machine
  // ****************************************
  typedef enum logic [3:0] {
    FSR_IDLE = 4'b0001,
    FSR_OPCODE = 4'b0010,
    FSR_STATUS = 4'b0100,
    FSR_IGNORE = 4'b1000
  } fsr_state_t;

endpackage

// ### core/fsr_status.sv
// Status flag bank of the serial flash with its status-read link
`timescale 1ns/100ps

// Function
// (RL1) Second byte bit 7 shows device idle
// (RL2) Second byte bits 6 and 4 read zero
// (RL3) Second byte bit 5 shows erase/program fault
// (RL4) Fault set when a byte fails
// (RL5) Aborted erase or program never sets fault
// (RL6) Fault updated after every erase or program
// (RL7) Second byte bit 3 shows lockdown permitted
// (RL8) Bit 2 second buffer suspend, blocks writes
// (RL9) Bit 1 first buffer suspend, blocks writes
// (RL10) Bit 0 set while any erase suspended
// (RL11) All second byte flags read only
// (RL12) Host polls status until idle rises
// (RL13) Differ flag holds last compare result
// (RL14) Fixed four-bit family density code
// (RL15) Density code separate from identification density
// (RL16) Guard flag shows software or hardware protection
// (RL17) Block length flag shows page size configuration
// (RL18) Opcode D7h streams byte one, two, repeating
// (RL19) First byte: idle, differ, density, guard, length
// (RL20) Block length reads one for 512 bytes
// (RL21) Chip select release ends read, floats output
// (RL22) Resume clears suspend flags; reset clears all
module fsr_status #(
  // Arbitrary value, stands in for the family code
  parameter logic [3:0] DENSITY_CODE = 4'h5,
  // Arbitrary value, density field of the identification read
  parameter logic [4:0] ID_DENSITY = 5'h06
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic spi_sck_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_si_i,
  output logic spi_so_o,
  output logic spi_so_oe_o,
  input wire logic protect_pin_n_i,
  input wire logic busy_i,
  input wire logic op_done_i,
  input wire logic op_fault_i,
  input wire logic op_abort_i,
  input wire logic cmp_done_i,
  input wire logic cmp_differ_i,
  input wire logic protect_sw_i,
  input wire logic page_512_i,
  input wire logic lockdown_permitted_i,
  input wire logic prog_suspend_i,
  input wire logic prog_suspend_buf2_i,
  input wire logic prog_resume_i,
  input wire logic prog_resume_buf2_i,
  input wire logic erase_suspend_i,
  input wire logic erase_resume_i,
  input wire logic buf1_wr_req_i,
  input wire logic buf2_wr_req_i,
  output logic buf1_wr_grant_o,
  output logic buf2_wr_grant_o,
  output logic [4:0] id_density_o
);
  import fsr_pkg::*;

  // ****************************************
  // Helpers
  // ****************************************
  // A pin change counts once the last two stages agree
  function automatic logic agree(input logic lvl, input logic [2:0] s);
    agree = (s[1] == s[2]) ? s[2] : lvl;
  endfunction

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [2:0] sck_sync_ff;
  logic [2:0] cs_sync_ff;
  logic [2:0] si_sync_ff;
  logic [2:0] prot_sync_ff;
  logic sck_ff;
  logic cs_n_ff;
  logic si_ff;
  logic prot_n_ff;
  logic nxt_sck;
  logic nxt_cs_n;
  logic sck_rise;
  logic sck_fall;
  logic cs_active;

  // Stage one only feeds stage two
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sck_sync_ff <= RST_SYNC_LO;
      cs_sync_ff <= RST_SYNC_HI;
      si_sync_ff <= RST_SYNC_LO;
      prot_sync_ff <= RST_SYNC_HI;
    end else if (ce_i) begin
      sck_sync_ff <= {sck_sync_ff[1:0], spi_sck_i};
      cs_sync_ff <= {cs_sync_ff[1:0], spi_cs_n_i};
      si_sync_ff <= {si_sync_ff[1:0], spi_si_i};
      prot_sync_ff <= {prot_sync_ff[1:0], protect_pin_n_i};
    end
  end

  assign nxt_sck = agree(sck_ff, sck_sync_ff);
  assign nxt_cs_n = agree(cs_n_ff, cs_sync_ff);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sck_ff <= RST_PIN_LO;
      cs_n_ff <= RST_PIN_HI;
      si_ff <= RST_PIN_LO;
      prot_n_ff <= RST_PIN_HI;
    end else if (ce_i) begin
      sck_ff <= nxt_sck;
      cs_n_ff <= nxt_cs_n;
      si_ff <= agree(si_ff, si_sync_ff);
      prot_n_ff <= agree(prot_n_ff, prot_sync_ff);
    end
  end

  // Edges only count inside a frame
  assign cs_active = ~cs_n_ff & ~nxt_cs_n;
  assign sck_rise = ce_i & cs_active & nxt_sck & ~sck_ff;
  assign sck_fall = ce_i & cs_active & ~nxt_sck & sck_ff;

  // ****************************************
  // Flag storage
  // ****************************************
  logic fault_ff;
  logic differ_ff;
  logic first_susp_ff;
  logic second_susp_ff;
  logic erase_hold_ff;
  logic first_susp_set;
  logic second_susp_set;

  // Aborted operations write a clean result, never a fault
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_ff <= RST_FAULT;
    end else if (ce_i && op_done_i) begin
      fault_ff <= op_fault_i & ~op_abort_i; // see RL4 see RL5 see RL6
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      differ_ff <= RST_DIFFER;
    end else if (ce_i && cmp_done_i) begin
      differ_ff <= cmp_differ_i; // see RL13
    end
  end

  assign first_susp_set = prog_suspend_i & ~prog_suspend_buf2_i;
  assign second_susp_set = prog_suspend_i & prog_suspend_buf2_i;

  // Set wins over a resume in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      first_susp_ff <= RST_SUSP; // see RL22
    end else if (ce_i) begin
      if (first_susp_set) begin
        first_susp_ff <= 1'b1; // see RL9
      end else if (prog_resume_i && !prog_resume_buf2_i) begin
        first_susp_ff <= 1'b0; // see RL22
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      second_susp_ff <= RST_SUSP; // see RL22
    end else if (ce_i) begin
      if (second_susp_set) begin
        second_susp_ff <= 1'b1; // see RL8
      end else if (prog_resume_i && prog_resume_buf2_i) begin
        second_susp_ff <= 1'b0; // see RL22
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      erase_hold_ff <= RST_SUSP; // see RL22
    end else if (ce_i) begin
      if (erase_suspend_i) begin
        erase_hold_ff <= 1'b1; // see RL10
      end else if (erase_resume_i) begin
        erase_hold_ff <= 1'b0; // see RL10
      end
    end
  end

  // Writes into a suspended buffer are dropped
  assign buf1_wr_grant_o = buf1_wr_req_i & ~first_susp_ff; // see RL9
  assign buf2_wr_grant_o = buf2_wr_req_i & ~second_susp_ff; // see RL8

  // Kept apart from the status density code
  assign id_density_o = ID_DENSITY; // see RL15

  // ****************************************
  // Status bytes
  // ****************************************
  logic [7:0] status_first_byte;
  logic [7:0] status_second_byte;

  always_comb begin
    status_first_byte = RST_BYTE;
    status_first_byte[B1_IDLE] = ~busy_i; // see RL1 see RL19
    status_first_byte[B1_DIFFER] = differ_ff; // see RL19
    status_first_byte[B1_DENS_HI:B1_DENS_LO] = DENSITY_CODE; // see RL14
    // Pin is active low, either source enables protection
    status_first_byte[B1_GUARD] = protect_sw_i | ~prot_n_ff; // see RL16
    status_first_byte[B1_BLOCK_LEN] = page_512_i; // see RL17 see RL20
  end

  // No write path exists, so host traffic cannot alter these
  always_comb begin
    status_second_byte = RST_BYTE; // see RL11
    status_second_byte[B2_IDLE] = ~busy_i; // see RL1
    status_second_byte[B2_UNUSED_HI] = 1'b0; // see RL2
    status_second_byte[B2_FAULT] = fault_ff; // see RL3
    status_second_byte[B2_UNUSED_LO] = 1'b0; // see RL2
    status_second_byte[B2_LOCKDOWN] = lockdown_permitted_i; // see RL7
    status_second_byte[B2_SECOND_SUSP] = second_susp_ff; // see RL8
    status_second_byte[B2_FIRST_SUSP] = first_susp_ff; // see RL9
    status_second_byte[B2_ERASE_HOLD] = erase_hold_ff; // see RL10
  end

  // ****************************************
  // Link state machine
  // ****************************************
  fsr_state_t state_ff;
  logic [2:0] bit_cnt_ff;
  logic [7:0] in_sr_ff;
  logic [7:0] out_sr_ff;
  logic byte_sel_ff;
  logic [7:0] opcode_word;

  assign opcode_word = {in_sr_ff[6:0], si_ff};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= FSR_IDLE;
    end else if (ce_i) begin
      if (!cs_active) begin
        state_ff <= FSR_IDLE; // see RL21
      end else begin
        case (state_ff)
          FSR_IDLE: begin
            state_ff <= FSR_OPCODE;
          end
          FSR_OPCODE: begin
            if (sck_rise && bit_cnt_ff == BIT_CNT_LAST) begin
              // Other opcodes belong to other blocks
              if (opcode_word == OPC_STATUS_READ) begin
                state_ff <= FSR_STATUS; // see RL18
              end else begin
                state_ff <= FSR_IGNORE;
              end
            end
          end
          FSR_STATUS: begin
            state_ff <= FSR_STATUS;
          end
          FSR_IGNORE: begin
            state_ff <= FSR_IGNORE;
          end
          default: begin
            state_ff <= FSR_IDLE;
          end
        endcase
      end
    end
  end

  // Opcode sampled on rising edges
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      in_sr_ff <= RST_BYTE;
    end else if (ce_i && state_ff == FSR_OPCODE && sck_rise) begin
      in_sr_ff <= opcode_word;
    end
  end

  // One counter serves opcode in and status out
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bit_cnt_ff <= BIT_CNT_RST;
    end else if (ce_i) begin
      if (!cs_active || state_ff == FSR_IDLE) begin
        bit_cnt_ff <= BIT_CNT_RST; // see RL21
      end else if (state_ff == FSR_OPCODE && sck_rise) begin
        bit_cnt_ff <= bit_cnt_ff + 3'h1;
      end else if (state_ff == FSR_STATUS && sck_fall) begin
        bit_cnt_ff <= bit_cnt_ff + 3'h1;
      end
    end
  end

  // Byte one first, then alternate for as long as clocks come
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      byte_sel_ff <= 1'b0;
    end else if (ce_i) begin
      if (state_ff != FSR_STATUS) begin
        byte_sel_ff <= 1'b0;
      end else if (sck_fall && bit_cnt_ff == BIT_CNT_LAST) begin
        byte_sel_ff <= ~byte_sel_ff; // see RL18
      end
    end
  end

  // Fresh snapshot at each byte start, so idle tracks every byte
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_sr_ff <= RST_BYTE;
      spi_so_o <= RST_SO;
    end else if (ce_i && state_ff == FSR_STATUS && sck_fall) begin
      if (bit_cnt_ff == BIT_CNT_RST) begin
        if (byte_sel_ff) begin
          spi_so_o <= status_second_byte[BYTE_BITS-1]; // see RL18
          out_sr_ff <= {status_second_byte[6:0], 1'b0};
        end else begin
          spi_so_o <= status_first_byte[BYTE_BITS-1]; // see RL18
          out_sr_ff <= {status_first_byte[6:0], 1'b0};
        end
      end else begin
        spi_so_o <= out_sr_ff[BYTE_BITS-1];
        out_sr_ff <= {out_sr_ff[6:0], 1'b0};
      end
    end
  end

  // Drive starts with the first data bit, stops on deselect
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      spi_so_oe_o <= 1'b0;
    end else if (ce_i) begin
      if (!cs_active || state_ff != FSR_STATUS) begin
        spi_so_oe_o <= 1'b0; // see RL21
      end else if (sck_fall) begin
        spi_so_oe_o <= 1'b1;
      end
    end
  end

endmodule // fsr_status

// ### tb/fsr_status_checker.sv
// Assertion checker for the flash status flag block
`timescale 1ns/100ps
// ****************************************
// Checker
// ****************************************
module fsr_status_checker #(
  parameter logic [4:0] ID_DENSITY = 5'h06
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic spi_sck_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_so_o,
  input wire logic spi_so_oe_o,
  input wire logic prog_suspend_i,
  input wire logic prog_suspend_buf2_i,
  input wire logic prog_resume_i,
  input wire logic prog_resume_buf2_i,
  input wire logic buf1_wr_req_i,
  input wire logic buf2_wr_req_i,
  input wire logic buf1_wr_grant_o,
  input wire logic buf2_wr_grant_o,
  input wire logic [4:0] id_density_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_susp1; ce_i && prog_suspend_i && !prog_suspend_buf2_i; endsequence
  sequence s_susp2; ce_i && prog_suspend_i && prog_suspend_buf2_i; endsequence
  sequence s_res1; ce_i && prog_resume_i && !prog_resume_buf2_i && !prog_suspend_i; endsequence
  sequence s_res2; ce_i && prog_resume_i && prog_resume_buf2_i && !prog_suspend_i; endsequence
  // Sync lag is up to four clocks, so seven is safe
  sequence s_cs_high; spi_cs_n_i [*7]; endsequence
  sequence s_sck_high; spi_sck_i [*3]; endsequence
  property p_susp1; s_susp1 |=> !buf1_wr_grant_o; endproperty
  property p_susp2; s_susp2 |=> !buf2_wr_grant_o; endproperty
  property p_res1; s_res1 |=> buf1_wr_grant_o == buf1_wr_req_i; endproperty
  property p_res2; s_res2 |=> buf2_wr_grant_o == buf2_wr_req_i; endproperty
  property p_grant;
    !((buf1_wr_grant_o && !buf1_wr_req_i) || (buf2_wr_grant_o && !buf2_wr_req_i));
  endproperty
  property p_iddens; id_density_o == ID_DENSITY; endproperty
  property p_cs_idle; s_cs_high |-> !spi_so_oe_o; endproperty
  property p_oe_rise; $rose(spi_so_oe_o) |-> !spi_cs_n_i; endproperty
  property p_so_hold; s_sck_high |-> $stable(spi_so_o); endproperty
  a_susp1: assert property (p_susp1) else $error("first buffer granted while held");
  a_susp2: assert property (p_susp2) else $error("second buffer granted while held");
  a_res1: assert property (p_res1) else $error("first buffer not freed");
  a_res2: assert property (p_res2) else $error("second buffer not freed");
  a_grant: assert property (p_grant) else $error("grant without request");
  a_iddens: assert property (p_iddens) else $error("identification density wrong");
  a_cs_idle: assert property (p_cs_idle) else $error("output driven while deselected");
  a_oe_rise: assert property (p_oe_rise) else $error("output enabled outside frame");
  a_so_hold: assert property (p_so_hold) else $error("output moved with clock high");
endmodule // fsr_status_checker

bind fsr_status fsr_status_checker #(.ID_DENSITY(ID_DENSITY)) i_fsr_status_checker (
  .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .spi_sck_i(spi_sck_i),
  .spi_cs_n_i(spi_cs_n_i), .spi_so_o(spi_so_o), .spi_so_oe_o(spi_so_oe_o),
  .prog_suspend_i(prog_suspend_i), .prog_suspend_buf2_i(prog_suspend_buf2_i),
  .prog_resume_i(prog_resume_i), .prog_resume_buf2_i(prog_resume_buf2_i),
  .buf1_wr_req_i(buf1_wr_req_i), .buf2_wr_req_i(buf2_wr_req_i),
  .buf1_wr_grant_o(buf1_wr_grant_o), .buf2_wr_grant_o(buf2_wr_grant_o),
  .id_density_o(id_density_o));

// ### tb/fsr_spi_host.sv
// Serial host model polling the flash status flags
`timescale 1ns/100ps
// ****************************************
// Host model
// ****************************************
module fsr_spi_host (
  output logic sck_o,
  output logic cs_n_o,
  output logic si_o,
  input wire logic so_i,
  input wire logic so_oe_i
);
  // Clock stands still low between frames
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b0;
  end
  // Samples late in the high phase, output lags the fall by the sync delay
  task automatic xfer(input logic [7:0] opc, input int nbits, output logic [31:0] got,
      output logic oe_any);
    got = '0;
    oe_any = 1'b0;
    #7 cs_n_o = 1'b0;
    #100;
    for (int i = 7; i >= 0; i--) begin
      si_o = opc[i];
      #100 sck_o = 1'b1;
      #100 sck_o = 1'b0;
    end
    for (int i = 0; i < nbits; i++) begin
      si_o = ~si_o;
      #100 sck_o = 1'b1;
      // A released output reads inverted, so data without drive shows up
      #95 got = {got[30:0], so_oe_i ? so_i : ~so_i};
      oe_any = oe_any | so_oe_i;
      #5 sck_o = 1'b0;
    end
    #100 cs_n_o = 1'b1;
    si_o = ~si_o;
    #200;
  endtask
endmodule // fsr_spi_host

// ### tb/fsr_status_tb_top.sv
// Testbench of the flash status flag block
`timescale 1ns/100ps
// ****************************************
// Bench top
// ****************************************
module fsr_status_tb_top;
  import fsr_pkg::*;
  localparam logic [3:0] DENS = 4'h9; // Arbitrary family code
  localparam logic [4:0] IDD = 5'h0a; // Arbitrary identification density
  logic clk_i, rst_i, ce_i, sck, cs_n, si, so, so_oe, prot_n, busy, op_fault, op_abort;
  logic cmp_differ, protect_sw, page_512, lockdown, susp_buf2, res_buf2, buf1_req, buf2_req;
  logic grant1, grant2, e_fault, e_diff, e_s1, e_s2, e_es, oe;
  logic [5:0] pls;
  logic [4:0] id_dens;
  logic [15:0] e;
  logic [31:0] got;
  int n_fail, n_checks;

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  fsr_status #(.DENSITY_CODE(DENS), .ID_DENSITY(IDD)) i_fsr_status (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .spi_sck_i(sck), .spi_cs_n_i(cs_n),
    .spi_si_i(si), .spi_so_o(so), .spi_so_oe_o(so_oe), .protect_pin_n_i(prot_n),
    .busy_i(busy), .op_done_i(pls[0]), .op_fault_i(op_fault), .op_abort_i(op_abort),
    .cmp_done_i(pls[1]), .cmp_differ_i(cmp_differ), .protect_sw_i(protect_sw),
    .page_512_i(page_512), .lockdown_permitted_i(lockdown), .prog_suspend_i(pls[2]),
    .prog_suspend_buf2_i(susp_buf2), .prog_resume_i(pls[3]), .prog_resume_buf2_i(res_buf2),
    .erase_suspend_i(pls[4]), .erase_resume_i(pls[5]), .buf1_wr_req_i(buf1_req),
    .buf2_wr_req_i(buf2_req), .buf1_wr_grant_o(grant1), .buf2_wr_grant_o(grant2),
    .id_density_o(id_dens));
  fsr_spi_host i_fsr_spi_host (.sck_o(sck), .cs_n_o(cs_n), .si_o(si), .so_i(so),
    .so_oe_i(so_oe));

  // ****************************************
  // Tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [15:0] exp16();
    return {~busy, e_diff, DENS, protect_sw | ~prot_n, page_512,
      ~busy, 1'b0, e_fault, 1'b0, lockdown, e_s2, e_s1, e_es};
  endfunction
  task automatic pulse(input int k);
    @(negedge clk_i) pls[k] = 1'b1;
    @(negedge clk_i) pls = '0;
  endtask
  task automatic read_all();
    @(negedge clk_i);
    i_fsr_spi_host.xfer(OPC_STATUS_READ, 32, got, oe);
    check(got, {exp16(), exp16()});
    check(oe, 1'b1);
    // Back on a falling edge before the caller drives anything
    @(negedge clk_i);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    n_fail = 0;
    n_checks = 0;
    rst_i = 1'b1;
    ce_i = 1'b1;
    prot_n = 1'b1;
    lockdown = 1'b1;
    pls = '0;
    {busy, op_fault, op_abort, cmp_differ, protect_sw, page_512} = '0;
    {susp_buf2, res_buf2, buf1_req, buf2_req} = '0;
    {e_fault, e_diff, e_s1, e_s2, e_es} = '0;
    repeat (5) @(negedge clk_i);
    rst_i = 1'b0;
    repeat (4) @(negedge clk_i);
    check(id_dens, IDD);
    read_all();
    busy = 1'b1;
    page_512 = 1'b1;
    protect_sw = 1'b1;
    lockdown = 1'b0;
    op_fault = 1'b1;
    cmp_differ = 1'b1;
    pulse(0);
    pulse(1);
    pulse(2);
    susp_buf2 = 1'b1;
    pulse(2);
    pulse(4);
    {e_fault, e_diff, e_s1, e_s2, e_es} = 5'h1f;
    buf1_req = 1'b1;
    buf2_req = 1'b1;
    @(negedge clk_i);
    check({grant1, grant2}, 2'h0);
    read_all();
    op_abort = 1'b1;
    pulse(0);
    cmp_differ = 1'b0;
    pulse(1);
    pulse(3);
    pulse(5);
    {e_fault, e_diff, e_s1, e_es} = 4'h0;
    busy = 1'b0;
    protect_sw = 1'b0;
    prot_n = 1'b0;
    page_512 = 1'b0;
    @(negedge clk_i);
    check({grant1, grant2}, 2'h2);
    read_all();
    // Clock enable low must swallow the pulse
    ce_i = 1'b0;
    pulse(4);
    ce_i = 1'b1;
    op_abort = 1'b0;
    pulse(0);
    res_buf2 = 1'b1;
    pulse(3);
    {e_fault, e_s2} = 2'h2;
    @(negedge clk_i);
    check(grant2, 1'b1);
    read_all();
    i_fsr_spi_host.xfer(8'h9f, 16, got, oe);
    check(oe, 1'b0);
    e = exp16();
    i_fsr_spi_host.xfer(OPC_STATUS_READ, 12, got, oe);
    check(got[11:0], e[15:4]);
    check(so_oe, 1'b0);
    // A cut frame must leave the next one starting at byte one
    read_all();
    // Busy drops while the second byte of one frame shifts out
    busy = 1'b1;
    e = exp16();
    fork
      i_fsr_spi_host.xfer(OPC_STATUS_READ, 32, got, oe);
      begin
        repeat (168) @(negedge clk_i);
        busy = 1'b0;
      end
    join
    check(got, {e, exp16()});
    // Reset in mid-run with flags set must clear them
    pulse(4);
    @(negedge clk_i);
    rst_i = 1'b1;
    repeat (2) @(negedge clk_i);
    rst_i = 1'b0;
    {e_fault, e_es} = 2'h0;
    repeat (4) @(negedge clk_i);
    read_all();
    conclude();
  end

  // Cuts a hang short
  initial begin
    #1000000;
    n_fail++;
    conclude();
  end
endmodule // fsr_status_tb_top
